/* rtl/ctp_pattern_gen.sv */
// Compliance test pattern generator with its management registers
//
// Operation
// - 0x27 bit 4 enables 10BASE-T patterns
// - 0x428 bit 4 enables 100BASE-TX modes
// - Selector picks pulse, repetitive, preamble, random patterns
// - Single bit then idle; four idle variants
// - 100BASE-TX code is {0x428[5], 0x27[3:0]}
// - Code sets zeros sent after each one
// - All-zero code clears the pattern shifter
`timescale 1ns/1ns
`default_nettype none
module ctp_pattern_gen (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire ctp_pkg::ctp_reg_req_type regReq,
	output logic [15:0] regRdData,
	input wire logic txNormalBit,
	input wire logic txNormalDrive,
	output ctp_pkg::ctp_line_type lineOut,
	output logic [15:0] dspTuning
);
	// ---------------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------------
	logic [15:0] selectReg_r;
	logic [15:0] extReg_r;
	logic [15:0] tuneReg_r;
	logic [15:0] rdData_r;
	logic [15:0] rdData_nxt;
	logic hitSel;
	logic hitExt;
	logic hitTune;

	// Address decode; unmapped reads return zero
	assign hitSel = (regReq.addr == ctp_pkg::CTP_OFS_COMPLIANCE_SELECT);
	assign hitExt = (regReq.addr == ctp_pkg::CTP_OFS_TX100_EXTENDED);
	assign hitTune = (regReq.addr == ctp_pkg::CTP_OFS_DSP_ENERGY_TUNING);
	assign rdData_nxt = hitSel ? selectReg_r : hitExt ? extReg_r : hitTune ? tuneReg_r : 16'h0000;

	// Only writable bits are stored; the rest read back as zero
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			selectReg_r <= ctp_pkg::CTP_RST_COMPLIANCE_SELECT;
			extReg_r <= ctp_pkg::CTP_RST_TX100_EXTENDED;
			tuneReg_r <= ctp_pkg::CTP_RST_DSP_ENERGY_TUNING;
		end else if (regReq.wr) begin
			if (hitSel)
				selectReg_r <= regReq.data & 16'h001F;
			if (hitExt)
				extReg_r <= regReq.data & 16'h0030;
			if (hitTune)
				tuneReg_r <= regReq.data & ctp_pkg::CTP_MASK_DSP_ENERGY_TUNING;
		end
	end

	// Read data registered one cycle after the read strobe
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			rdData_r <= 16'h0000;
		else if (regReq.rd)
			rdData_r <= rdData_nxt;
	end

	assign regRdData = rdData_r;
	assign dspTuning = tuneReg_r;

	// ---------------------------------------------------------------------
	// Mode control
	// ---------------------------------------------------------------------
	logic tenEn;
	logic hundredEn;
	logic [3:0] sel;
	logic [4:0] txCode;
	ctp_pkg::ctp_state_type state_r;
	ctp_pkg::ctp_state_type state_nxt;
	logic [3:0] selSeen_r;
	logic restart;
	logic hundredLoad;

	assign tenEn = selectReg_r[ctp_pkg::CTP_BIT_TEST_ENABLE];
	assign hundredEn = extReg_r[ctp_pkg::CTP_BIT_TEST_ENABLE];
	assign sel = selectReg_r[ctp_pkg::CTP_SEL_MSB:0];
	assign txCode = {extReg_r[ctp_pkg::CTP_BIT_TX100_MSB], sel};

	// 100BASE-TX takes priority when both enables are set
	always_comb begin
		case (state_r)
			ctp_pkg::CTP_ST_NORMAL: state_nxt = hundredEn ? ctp_pkg::CTP_ST_HUNDRED :
				tenEn ? ctp_pkg::CTP_ST_TEN : ctp_pkg::CTP_ST_NORMAL;
			ctp_pkg::CTP_ST_TEN: state_nxt = hundredEn ? ctp_pkg::CTP_ST_HUNDRED :
				tenEn ? ctp_pkg::CTP_ST_TEN : ctp_pkg::CTP_ST_NORMAL;
			ctp_pkg::CTP_ST_HUNDRED: state_nxt = hundredEn ? ctp_pkg::CTP_ST_HUNDRED :
				tenEn ? ctp_pkg::CTP_ST_TEN : ctp_pkg::CTP_ST_NORMAL;
			default: state_nxt = ctp_pkg::CTP_ST_NORMAL;
		endcase
	end

	// Pattern is latched only on entry, so reselecting needs an off/on cycle
	assign hundredLoad = (state_nxt == ctp_pkg::CTP_ST_HUNDRED) &&
		(state_r != ctp_pkg::CTP_ST_HUNDRED);
	// 10BASE-T patterns restart when entered or when the selector moves
	assign restart = (state_nxt == ctp_pkg::CTP_ST_TEN) &&
		((state_r != ctp_pkg::CTP_ST_TEN) || (sel != selSeen_r));

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_r <= ctp_pkg::CTP_ST_NORMAL;
			selSeen_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			selSeen_r <= sel;
		end
	end

	// ---------------------------------------------------------------------
	// 10 Mb/s bit-time enable
	// ---------------------------------------------------------------------
	logic [3:0] div_r;
	logic tenStep;

	assign tenStep = (div_r == 4'(ctp_pkg::CTP_TEN_BIT_CYCLES - 1));

	always_ff @(posedge clk_sys) begin
		if (!rstn || restart || tenStep)
			div_r <= 4'h0;
		else
			div_r <= div_r + 4'h1;
	end

	// ---------------------------------------------------------------------
	// 10BASE-T pattern sequencer
	// ---------------------------------------------------------------------
	logic shotDone_r;
	logic [1:0] phase_r;
	logic [15:0] lfsr_r;
	logic lfsrFb;
	logic shotPat;
	logic idlePat;
	logic tenBit;
	logic tenDrive;
	logic tenPulse;

	// Single-shot codes send one bit time, then fall quiet or to idle
	assign shotPat = (sel == ctp_pkg::CTP_PAT_LINK_PULSE) ||
		(sel == ctp_pkg::CTP_PAT_SINGLE_ONE) || (sel == ctp_pkg::CTP_PAT_SINGLE_ZERO) ||
		(sel == ctp_pkg::CTP_PAT_ONE_THEN_IDLE) ||
		(sel == ctp_pkg::CTP_PAT_ZERO_THEN_IDLE);
	assign idlePat = (sel >= ctp_pkg::CTP_PAT_IDLE_00) &&
		(sel <= ctp_pkg::CTP_PAT_IDLE_11);
	assign lfsrFb = lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10];

	always_ff @(posedge clk_sys) begin
		if (!rstn || restart) begin
			shotDone_r <= 1'b0;
			phase_r <= 2'h0;
			lfsr_r <= ctp_pkg::CTP_LFSR_SEED;
		end else if (tenStep) begin
			shotDone_r <= 1'b1;
			phase_r <= phase_r + 2'h1;
			lfsr_r <= {lfsr_r[14:0], lfsrFb};
		end
	end

	// Bit value per selector code
	always_comb begin
		tenBit = 1'b0;
		tenDrive = !shotDone_r || !shotPat;
		tenPulse = 1'b0;
		case (sel)
			ctp_pkg::CTP_PAT_LINK_PULSE: begin
				tenPulse = !shotDone_r;
				tenBit = !shotDone_r;
			end
			ctp_pkg::CTP_PAT_SINGLE_ONE: tenBit = 1'b1;
			ctp_pkg::CTP_PAT_SINGLE_ZERO: tenBit = 1'b0;
			ctp_pkg::CTP_PAT_REP_ONE: tenBit = 1'b1;
			ctp_pkg::CTP_PAT_REP_ZERO: tenBit = 1'b0;
			ctp_pkg::CTP_PAT_PREAMBLE: tenBit = !phase_r[0];
			ctp_pkg::CTP_PAT_ONE_THEN_IDLE: tenBit = 1'b1;
			ctp_pkg::CTP_PAT_ZERO_THEN_IDLE: tenBit = 1'b0;
			ctp_pkg::CTP_PAT_REP_1001: tenBit = ctp_pkg::CTP_SEQ_1001[2'h3 - phase_r];
			ctp_pkg::CTP_PAT_RANDOM: tenBit = lfsr_r[15];
			default: begin
				tenBit = 1'b0;
				tenDrive = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------------
	// 100BASE-TX shifter, stepped every core cycle
	// ---------------------------------------------------------------------
	logic hundredBit;

	ctp_zero_run u_zeroRun (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.load(hundredLoad),
		.code(txCode),
		.step(state_r == ctp_pkg::CTP_ST_HUNDRED),
		.bitOut(hundredBit)
	);

	// ---------------------------------------------------------------------
	// Line output mux, registered
	// ---------------------------------------------------------------------
	ctp_pkg::ctp_line_type line_r;
	ctp_pkg::ctp_line_type line_nxt;

	// Test data replaces normal data for as long as a mode is on
	always_comb begin
		line_nxt = '0;
		case (state_r)
			ctp_pkg::CTP_ST_NORMAL: begin
				line_nxt.driveEn = txNormalDrive;
				line_nxt.lineBit = txNormalBit;
			end
			ctp_pkg::CTP_ST_TEN: begin
				line_nxt.testActive = 1'b1;
				line_nxt.driveEn = tenDrive;
				line_nxt.lineBit = tenBit;
				line_nxt.linkPulse = tenPulse;
				line_nxt.idleWave = idlePat || (shotDone_r &&
					(sel == ctp_pkg::CTP_PAT_ONE_THEN_IDLE ||
					sel == ctp_pkg::CTP_PAT_ZERO_THEN_IDLE));
				line_nxt.idleVariant = idlePat ? sel[1:0] - 2'h2 : 2'h0;
			end
			ctp_pkg::CTP_ST_HUNDRED: begin
				line_nxt.testActive = 1'b1;
				line_nxt.driveEn = 1'b1;
				line_nxt.lineBit = hundredBit;
			end
			default: line_nxt = '0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			line_r <= '0;
		else
			line_r <= line_nxt;
	end

	assign lineOut = line_r;
endmodule // ctp_pattern_gen
`default_nettype wire

/* inc/ctp_pkg.sv */
// Package for the compliance test pattern block: map, fields, codes, states
`default_nettype none
package ctp_pkg;
	// -------------------------------------------------------------------
	// Register map and reset values
	// -------------------------------------------------------------------
	localparam logic [15:0] CTP_OFS_COMPLIANCE_SELECT = 16'h0027;
	localparam logic [15:0] CTP_OFS_TX100_EXTENDED = 16'h0428;
	localparam logic [15:0] CTP_OFS_DSP_ENERGY_TUNING = 16'h0101;
	localparam logic [15:0] CTP_RST_COMPLIANCE_SELECT = 16'h0000;
	localparam logic [15:0] CTP_RST_TX100_EXTENDED = 16'h0000;
	localparam logic [15:0] CTP_RST_DSP_ENERGY_TUNING = 16'h2082;
	// Reserved bits 6:5 of the tuning register read as zero
	localparam logic [15:0] CTP_MASK_DSP_ENERGY_TUNING = 16'hFF9F;

	// -------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------
	localparam int CTP_BIT_TEST_ENABLE = 4;
	localparam int CTP_BIT_TX100_MSB = 5;
	localparam int CTP_SEL_MSB = 3;

	// -------------------------------------------------------------------
	// 10BASE-T pattern codes
	// -------------------------------------------------------------------
	localparam logic [3:0] CTP_PAT_LINK_PULSE = 4'h0;
	localparam logic [3:0] CTP_PAT_SINGLE_ONE = 4'h1;
	localparam logic [3:0] CTP_PAT_SINGLE_ZERO = 4'h2;
	localparam logic [3:0] CTP_PAT_REP_ONE = 4'h3;
	localparam logic [3:0] CTP_PAT_REP_ZERO = 4'h4;
	localparam logic [3:0] CTP_PAT_PREAMBLE = 4'h5;
	localparam logic [3:0] CTP_PAT_ONE_THEN_IDLE = 4'h6;
	localparam logic [3:0] CTP_PAT_ZERO_THEN_IDLE = 4'h7;
	localparam logic [3:0] CTP_PAT_REP_1001 = 4'h8;
	localparam logic [3:0] CTP_PAT_RANDOM = 4'h9;
	localparam logic [3:0] CTP_PAT_IDLE_00 = 4'hA;
	localparam logic [3:0] CTP_PAT_IDLE_11 = 4'hD;
	localparam logic [3:0] CTP_SEQ_1001 = 4'h9;

	// -------------------------------------------------------------------
	// Timing: 10 Mb/s bit time from the 50 MHz core clock
	// -------------------------------------------------------------------
	localparam int CTP_CLK_HZ = 50000000;
	localparam int CTP_TEN_BIT_NS = 100;
	localparam int CTP_TEN_BIT_CYCLES = (CTP_TEN_BIT_NS * (CTP_CLK_HZ / 1000000)) / 1000;
	localparam logic [15:0] CTP_LFSR_SEED = 16'hACE1;

	// -------------------------------------------------------------------
	// Carriers and states
	// -------------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] data;
	} ctp_reg_req_type;

	typedef struct packed {
		logic testActive;
		logic driveEn;
		logic lineBit;
		logic linkPulse;
		logic idleWave;
		logic [1:0] idleVariant;
	} ctp_line_type;

	typedef enum logic [2:0] {
		CTP_ST_NORMAL = 3'b001,
		CTP_ST_TEN = 3'b010,
		CTP_ST_HUNDRED = 3'b100
	} ctp_state_type;
endpackage
`default_nettype wire

/* rtl/ctp_zero_run.sv */
// One-then-N-zeros pattern shifter for the 100BASE-TX test modes
`timescale 1ns/1ns
`default_nettype none
module ctp_zero_run (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic load,
	input wire logic [4:0] code,
	input wire logic step,
	output logic bitOut
);
	logic [4:0] zeros_r;
	logic [4:0] zeros_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic bit_r;
	logic bit_nxt;
	logic clearAll;
	logic [4:0] mapped;

	// Code 06 asks for five zeros; every other code is its own count
	assign mapped = (code == 5'h06) ? 5'h05 : code;
	// Taken from the latched count, so a selector moved mid-test has no effect
	assign clearAll = (zeros_r == 5'h00);
	assign zeros_nxt = load ? mapped : zeros_r;
	// Emit the one when the run of zeros has been spent
	assign cnt_nxt = (load || cnt_r == zeros_r) ? 5'h00 : cnt_r + 5'h01;
	assign bit_nxt = (load || clearAll) ? 1'b0 : (cnt_nxt == 5'h00);

	// ---------------------------------------------------------------------
	// Shifter state
	// ---------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			zeros_r <= 5'h00;
			cnt_r <= 5'h00;
			bit_r <= 1'b0;
		end else if (load || step) begin
			zeros_r <= zeros_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
		end
	end

	assign bitOut = bit_r;
endmodule // ctp_zero_run
`default_nettype wire

/* sim/ctp_pattern_props.sv */
// Checker on the ports of the compliance pattern generator
`timescale 1ns/1ns
`default_nettype none
module ctp_pattern_props (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire ctp_pkg::ctp_reg_req_type regReq,
	input wire logic [15:0] regRdData,
	input wire logic txNormalBit,
	input wire logic txNormalDrive,
	input wire ctp_pkg::ctp_line_type lineOut,
	input wire logic [15:0] dspTuning
);
	// ------------------------------------------------------------
	// Decode and properties
	// ------------------------------------------------------------
	// Address decode for the three mapped words
	wire logic atTune = regReq.addr == ctp_pkg::CTP_OFS_DSP_ENERGY_TUNING;
	wire logic atMapped = atTune || regReq.addr == ctp_pkg::CTP_OFS_COMPLIANCE_SELECT
		|| regReq.addr == ctp_pkg::CTP_OFS_TX100_EXTENDED;
	wire logic atSel = regReq.addr == ctp_pkg::CTP_OFS_COMPLIANCE_SELECT;
	wire logic atExt = regReq.addr == ctp_pkg::CTP_OFS_TX100_EXTENDED;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	reset_values_a: assert property (disable iff (1'b0) !rstn |=> regRdData == 16'h0000
		&& lineOut == '0 && dspTuning == 16'h2082) else $error("reset values wrong");
	tune_write_a: assert property (regReq.wr && atTune |=> dspTuning ==
		($past(regReq.data) & ctp_pkg::CTP_MASK_DSP_ENERGY_TUNING)) else $error("tuning write");
	tune_hold_a: assert property (!(regReq.wr && atTune) |=> $stable(dspTuning))
		else $error("tuning changed");
	unmapped_read_a: assert property (regReq.rd && !atMapped |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	select_read_a: assert property (regReq.rd && atSel |=>
		regRdData[15:5] == 11'h000) else $error("select reserved bits set");
	ext_read_a: assert property (regReq.rd && atExt |=>
		regRdData[15:6] == 10'h000 && regRdData[3:0] == 4'h0)
		else $error("extended reserved bits set");
	idle_quiet_a: assert property (lineOut.idleWave |->
		!lineOut.driveEn && lineOut.testActive) else $error("idle wave while driving");
	pulse_shape_a: assert property (lineOut.linkPulse |->
		lineOut.driveEn && lineOut.lineBit) else $error("link pulse not driven high");
	read_hold_a: assert property (!regReq.rd |=> $stable(regRdData)) else $error("read data moved");
	normal_pass_a: assert property (!lineOut.testActive && $past(rstn) |->
		lineOut.lineBit == $past(txNormalBit) && lineOut.driveEn == $past(txNormalDrive))
		else $error("normal data not passed");
	test_start_a: assert property ($rose(lineOut.testActive) |->
		$past(regReq.wr, 2) || $past(regReq.wr, 3)) else $error("test began unasked");
endmodule // ctp_pattern_props
bind ctp_pattern_gen ctp_pattern_props i_props (.clk_sys(clk_sys), .rstn(rstn),
	.regReq(regReq), .regRdData(regRdData), .txNormalBit(txNormalBit),
	.txNormalDrive(txNormalDrive), .lineOut(lineOut), .dspTuning(dspTuning));
`default_nettype wire

/* sim/ctp_line_partner.sv */
// Line-side test equipment model that measures zero runs on the pair
`timescale 1ns/1ns
`default_nettype none
module ctp_line_partner (
	input wire logic clk_sys,
	input wire ctp_pkg::ctp_line_type lineIn,
	output logic [7:0] lastRun,
	output logic [15:0] oneCount
);
	logic [7:0] run = 8'h00;
	logic [7:0] last = 8'h00;
	logic [15:0] ones = 16'h0000;
	// Runs counted in core clocks; a held one only closes a run once
	always @(posedge clk_sys) begin
		if (lineIn.driveEn && lineIn.lineBit) begin
			if (run != 8'h00) last <= run;
			run <= 8'h00;
			ones <= ones + 16'h0001;
		end else if (lineIn.driveEn) begin
			run <= run + 8'h01;
		end
	end
	assign lastRun = last;
	assign oneCount = ones;
endmodule // ctp_line_partner
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the compliance pattern generator
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk_sys;
	logic rstn;
	logic txNormalBit;
	logic txNormalDrive;
	logic [15:0] regRdData;
	logic [15:0] dspTuning;
	logic [7:0] lastRun;
	logic [15:0] oneCount;
	logic [15:0] n;
	ctp_pkg::ctp_reg_req_type regReq;
	ctp_pkg::ctp_line_type lineOut;
	int numErrors = 0;
	int comparisons = 0;
	localparam logic [15:0] SEL = ctp_pkg::CTP_OFS_COMPLIANCE_SELECT;
	localparam logic [15:0] EXT = ctp_pkg::CTP_OFS_TX100_EXTENDED;
	localparam logic [15:0] TUNE = ctp_pkg::CTP_OFS_DSP_ENERGY_TUNING;
	// Rows: select word, extended word, expected zero run in clocks
	logic [47:0] rows [8] = '{48'h0015_0000_0005, 48'h0018_0000_000A,
		48'h0001_0010_0001, 48'h0002_0010_0002, 48'h0013_0010_0003,
		48'h0006_0010_0005, 48'h0007_0010_0007, 48'h0001_0030_0011};
	// Per 10BASE-T code: line view in the first bit time, then in the second
	logic [15:0] codeExp [14] = '{16'h7840, 16'h7040, 16'h6040, 16'h7070, 16'h6060,
		16'h7060, 16'h7044, 16'h6044, 16'h7060, 16'h7060, 16'h4444, 16'h4545,
		16'h4646, 16'h4747};
	// Line fields packed for compare; an undriven bit is shown as zero
	wire logic [15:0] lineView = {9'h000, lineOut.testActive, lineOut.driveEn,
		lineOut.driveEn & lineOut.lineBit, lineOut.linkPulse, lineOut.idleWave,
		lineOut.idleVariant};
	ctp_pattern_gen i_dut (.clk_sys(clk_sys), .rstn(rstn), .regReq(regReq),
		.regRdData(regRdData), .txNormalBit(txNormalBit), .txNormalDrive(txNormalDrive),
		.lineOut(lineOut), .dspTuning(dspTuning));
	ctp_line_partner i_line (.clk_sys(clk_sys), .lineIn(lineOut), .lastRun(lastRun),
		.oneCount(oneCount));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One request held across exactly one rising edge
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		regReq = '{w, !w, a, d};
		@(negedge clk_sys);
		regReq = '0;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
		xfer(1'b0, a, 16'h0000);
		chk("read data", regRdData, exp);
	endtask
	task automatic summarize;
		$display("comparisons %0d numErrors %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Watchdog against a hung run
	initial begin
		#1000000;
		numErrors++;
		summarize();
	end
	// Speed is taken as forced beforehand
	initial begin
		rstn = 1'b0;
		regReq = '0;
		txNormalBit = 1'b0;
		txNormalDrive = 1'b0;
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		rdchk(SEL, 16'h0000);
		rdchk(EXT, 16'h0000);
		rdchk(TUNE, 16'h2082);
		xfer(1'b1, TUNE, 16'hFFFF);
		rdchk(TUNE, 16'hFF9F);
		chk("tuning", dspTuning, 16'hFF9F);
		xfer(1'b1, SEL, 16'hFFFF);
		rdchk(SEL, 16'h001F);
		xfer(1'b1, EXT, 16'hFFFF);
		rdchk(EXT, 16'h0030);
		xfer(1'b1, 16'h0100, 16'hFFFF);
		rdchk(16'h0100, 16'h0000);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, EXT, 16'h0000);
			xfer(1'b1, SEL, rows[i][47:32]);
			xfer(1'b1, EXT, rows[i][31:16]);
			repeat (60) @(negedge clk_sys);
			chk("zero run", {8'h00, lastRun}, rows[i][15:0]);
		end
		$display("test pattern rows done");
		// New selection ignored until the enable is toggled
		xfer(1'b1, EXT, 16'h0000);
		xfer(1'b1, SEL, 16'h0001);
		xfer(1'b1, EXT, 16'h0010);
		xfer(1'b1, SEL, 16'h0003);
		repeat (40) @(negedge clk_sys);
		chk("held run", {8'h00, lastRun}, 16'h0001);
		xfer(1'b1, EXT, 16'h0000);
		xfer(1'b1, EXT, 16'h0010);
		repeat (40) @(negedge clk_sys);
		chk("new run", {8'h00, lastRun}, 16'h0003);
		$display("test reconfigure done");
		xfer(1'b1, EXT, 16'h0000);
		xfer(1'b1, SEL, 16'h0000);
		xfer(1'b1, EXT, 16'h0010);
		repeat (5) @(negedge clk_sys);
		n = oneCount;
		repeat (30) @(negedge clk_sys);
		chk("cleared ones", oneCount, n);
		chk("cleared drive", {15'h0000, lineOut.driveEn}, 16'h0001);
		$display("test cleared shifter done");
		xfer(1'b1, EXT, 16'h0000);
		for (logic [15:0] c = 16'h0000; c < 16'h000E; c++) begin
			xfer(1'b1, SEL, 16'h0010 | c);
			repeat (3) @(negedge clk_sys);
			chk("ten active", {15'h0000, lineOut.testActive}, 16'h0001);
			chk("first bit", lineView, {8'h00, codeExp[c][15:8]});
			repeat (5) @(negedge clk_sys);
			chk("second bit", lineView, {8'h00, codeExp[c][7:0]});
		end
		xfer(1'b1, SEL, 16'h0000);
		txNormalBit = 1'b1;
		txNormalDrive = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk("normal", {13'h0000, lineOut.testActive, lineOut.driveEn, lineOut.lineBit},
			16'h0003);
		$display("test codes and normal done");
		xfer(1'b1, EXT, 16'h0010);
		xfer(1'b1, TUNE, 16'h0000);
		rstn = 1'b0;
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		chk("reset line", {15'h0000, lineOut.testActive}, 16'h0000);
		rdchk(EXT, 16'h0000);
		rdchk(TUNE, 16'h2082);
		$display("test second reset done");
		summarize();
	end
endmodule // testbench
`default_nettype wire
